// [rtl/pmsc_consts.svh]
// constants for the power sequence control block
// assumes a 125 MHz system clock; long counts are overridable parameters
// Notes on behaviour
// - wake releases on button or acknowledge
// - acknowledge low pulls wake low
// - key status mirrors button after 50ms
// - button high idle, low pressed
// - reset low on undervoltage or hard reset
// - each regulator follows its enable input
// - ldo cd enable drives both, software may disable
// - single pin variant enables only third
// - alert low on pg, uv, ot events
// - write to alert clear releases alert
// - standby low: targets from select bits
// - standby high: force alternate targets
// - rails ok low when enabled rail low
// - rails ok low while slewing unless masked
// - rails ok low when all disabled
// - logic supply loss resets registers
// - fourth regulator level from software select
// - 400ms press releases wake
// - 5s press: all off, reset 1s
// - inputs ignored one second after hard reset
// - internal enables delayed 200us
`ifndef PMSC_CONSTS_SVH
`define PMSC_CONSTS_SVH
`define PMSC_CLK_MHZ        125
`define PMSC_DEBOUNCE_MS    50
`define PMSC_WAKE_PRESS_MS  400
`define PMSC_HARD_PRESS_MS  5000
`define PMSC_HARD_RST_MS    1000
`define PMSC_ACK_WAIT_MS    5000
`define PMSC_EN_DELAY_US    200
`define PMSC_EN_DELAY_CYC   (`PMSC_EN_DELAY_US * `PMSC_CLK_MHZ)
`define PMSC_MS_CYC         (1000 * `PMSC_CLK_MHZ)
`define PMSC_REG_CTRL       12'h000
`define PMSC_REG_ALERT_CLR  12'h004
`define PMSC_REG_VCHOICE    12'h008
`define PMSC_REG_STATUS     12'h00C
`define PMSC_REG_ALERT      12'h010
`define PMSC_NREG           7
`endif

// [rtl/pmsc_pkg.sv]
// types shared by the power sequence control block
// assumes the constants header is included by users of timing values
package pmsc_pkg;
	typedef enum logic [2:0] {
		PMSC_OFF     = 3'b000,
		PMSC_WAKING  = 3'b001,
		PMSC_ON      = 3'b010,
		PMSC_HARDRST = 3'b011,
		PMSC_INHIBIT = 3'b100
	} pmsc_state_t;
endpackage

// [rtl/pmsc_power_sequence_control.sv]
// pushbutton, wake handshake, reset, alert, power-good and enable logic
// assumes all pins synchronous to clk_sys; regulator status arrives as levels
//
// The implementer's own choices: register access over APB and the placing of the registers.
`include "pmsc_consts.svh"
module pmsc_power_sequence_control
	import pmsc_pkg::*;
#(
	parameter int unsigned MS_CYC   = `PMSC_MS_CYC,
	parameter int unsigned EN_DLY   = `PMSC_EN_DELAY_CYC,
	parameter int unsigned DEB_MS   = `PMSC_DEBOUNCE_MS,
	parameter int unsigned WAKE_MS  = `PMSC_WAKE_PRESS_MS,
	parameter int unsigned HARD_MS  = `PMSC_HARD_PRESS_MS,
	parameter int unsigned HRST_MS  = `PMSC_HARD_RST_MS,
	parameter int unsigned ACK_MS   = `PMSC_ACK_WAIT_MS,
	parameter bit          SINGLE_C = 1'b0
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        logic_supply_ok,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        push_key_n,
	input  wire logic        host_power_ack,
	input  wire logic        ldo_b_enable,
	input  wire logic        buck_a_enable,
	input  wire logic        buck_b_enable,
	input  wire logic        buck_c_enable,
	input  wire logic        bb_enable,
	input  wire logic        ldo_cd_enable,
	input  wire logic        standby_volt_sel,
	input  wire logic        always_alive_ok,
	input  wire logic [6:0]  rail_good,
	input  wire logic [6:0]  rail_slewing,
	input  wire logic        uv_event,
	input  wire logic        ot_event,
	output logic             system_up_out,
	output logic             system_up_oe,
	output logic             key_state_out,
	output logic             key_state_oe,
	output logic             reset_out_n,
	output logic             reset_out_oe,
	output logic             alert_out_n,
	output logic             alert_out_oe,
	output logic             rails_ok_out,
	output logic             rails_ok_oe,
	output logic [6:0]       rail_enable,
	output logic [3:0]       dac_use_alt,
	output logic [1:0]       ldo_d_level
);
	// rail index: 0 buck_a 1 buck_b 2 buck_c 3 bb 4 ldo_b 5 ldo_c 6 ldo_d
	logic        rst_all_n;
	logic        sync1_r;
	logic        sync2_r;
	logic [16:0] tick_cnt_r;
	logic        ms_tick;
	logic [12:0] press_ms_r;
	logic [12:0] state_ms_r;
	logic [5:0]  deb_ms_r;
	logic        key_state_r;
	logic        key_sync_r;
	pmsc_state_t state_r;
	pmsc_state_t state_nxt;
	logic [31:0] ctrl_r;
	logic [7:0]  vchoice_r;
	logic        alert_r;
	logic [6:0]  pin_en;
	logic [6:0]  en_dly_r;
	logic [14:0] dly_cnt_r [7];
	logic        pressed;
	logic        inhibit;
	logic        pg_fail;
	logic        any_en;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic        alert_set;

	// logic supply loss acts as a register reset on top of the pin reset
	assign rst_all_n = reset_n & logic_supply_ok;

	// two-stage synchroniser on the button; only the second stage is used
	always_ff @(posedge clk_sys or negedge rst_all_n) begin
		if (!rst_all_n) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= push_key_n;
			sync2_r <= sync1_r;
		end
	end
	assign pressed = ~sync2_r;

	// free-running millisecond timebase
	assign ms_tick = (tick_cnt_r == 17'(MS_CYC - 1));
	always_ff @(posedge clk_sys or negedge rst_all_n) begin
		if (!rst_all_n)
			tick_cnt_r <= 17'h0_0000;
		else
			tick_cnt_r <= ms_tick ? 17'h0_0000 : tick_cnt_r + 17'h0_0001;
	end

	assign inhibit = (state_r == PMSC_INHIBIT) || (state_r == PMSC_HARDRST);

	// press duration counter and debounced status
	always_ff @(posedge clk_sys or negedge rst_all_n) begin
		if (!rst_all_n) begin
			press_ms_r  <= 13'h0000;
			deb_ms_r    <= 6'h00;
			key_sync_r  <= 1'b1;
			key_state_r <= 1'b1;
		end else begin
			key_sync_r <= sync2_r;
			if (!pressed || inhibit)
				press_ms_r <= 13'h0000;
			else if (ms_tick && press_ms_r != 13'h1FFF)
				press_ms_r <= press_ms_r + 13'h0001;
			if (key_sync_r != sync2_r)
				deb_ms_r <= 6'h00;
			else if (ms_tick && deb_ms_r != 6'(DEB_MS))
				deb_ms_r <= deb_ms_r + 6'h01;
			// level must be stable for the debounce time before it is mirrored
			if (deb_ms_r == 6'(DEB_MS) && !inhibit)
				key_state_r <= sync2_r;
		end
	end

	// wake / hard reset sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PMSC_OFF: begin
				if (host_power_ack || press_ms_r >= 13'(WAKE_MS))
					state_nxt = PMSC_WAKING;
			end
			PMSC_WAKING: begin
				if (press_ms_r >= 13'(HARD_MS))
					state_nxt = PMSC_HARDRST;
				else if (host_power_ack)
					state_nxt = PMSC_ON;
				else if (state_ms_r >= 13'(ACK_MS))
					state_nxt = PMSC_OFF;
			end
			PMSC_ON: begin
				if (press_ms_r >= 13'(HARD_MS))
					state_nxt = PMSC_HARDRST;
				else if (!host_power_ack)
					state_nxt = PMSC_OFF;
			end
			PMSC_HARDRST: begin
				if (state_ms_r >= 13'(HRST_MS))
					state_nxt = PMSC_INHIBIT;
			end
			PMSC_INHIBIT: begin
				if (state_ms_r >= 13'(HRST_MS))
					state_nxt = PMSC_OFF;
			end
			default: state_nxt = PMSC_OFF;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_all_n) begin
		if (!rst_all_n) begin
			state_r    <= PMSC_OFF;
			state_ms_r <= 13'h0000;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r)
				state_ms_r <= 13'h0000;
			else if (ms_tick && state_ms_r != 13'h1FFF)
				state_ms_r <= state_ms_r + 13'h0001;
		end
	end

	// regulator enables: pin level delayed, forced off during hard reset
	assign pin_en[0] = buck_a_enable;
	assign pin_en[1] = buck_b_enable;
	assign pin_en[2] = buck_c_enable;
	assign pin_en[3] = bb_enable;
	assign pin_en[4] = ldo_b_enable;
	assign pin_en[5] = ldo_cd_enable;
	// software may veto the fourth ldo through ctrl bit 8
	assign pin_en[6] = SINGLE_C ? 1'b0 : (ldo_cd_enable & ~ctrl_r[8]);

	genvar gi;
	generate
		for (gi = 0; gi < `PMSC_NREG; gi++) begin : g_dly
			always_ff @(posedge clk_sys or negedge rst_all_n) begin
				if (!rst_all_n) begin
					dly_cnt_r[gi] <= 15'h0000;
					en_dly_r[gi]  <= 1'b0;
				end else if (inhibit) begin
					dly_cnt_r[gi] <= 15'h0000;
					en_dly_r[gi]  <= 1'b0;
				end else if (pin_en[gi] == en_dly_r[gi]) begin
					dly_cnt_r[gi] <= 15'h0000;
				end else if (dly_cnt_r[gi] == 15'(EN_DLY - 1)) begin
					dly_cnt_r[gi] <= 15'h0000;
					en_dly_r[gi]  <= pin_en[gi];
				end else begin
					dly_cnt_r[gi] <= dly_cnt_r[gi] + 15'h0001;
				end
			end
		end
	endgenerate
	assign rail_enable = en_dly_r;

	// power good: ctrl bit 0 masks slewing from the power-good pin
	assign any_en  = |en_dly_r;
	assign pg_fail = |(en_dly_r & ~rail_good);
	always_ff @(posedge clk_sys or negedge rst_all_n) begin
		if (!rst_all_n)
			rails_ok_out <= 1'b0;
		else
			rails_ok_out <= any_en & ~pg_fail
				& ~(~ctrl_r[0] & |(en_dly_r & rail_slewing));
	end

	// dac target select
	assign dac_use_alt = standby_volt_sel ? 4'hF : vchoice_r[3:0];
	assign ldo_d_level = ctrl_r[5:4];

	// apb slave, zero wait states
	assign addr_ok = (paddr == `PMSC_REG_CTRL) || (paddr == `PMSC_REG_ALERT_CLR) ||
		(paddr == `PMSC_REG_VCHOICE) || (paddr == `PMSC_REG_STATUS) ||
		(paddr == `PMSC_REG_ALERT);
	assign wr_en   = psel & penable & pwrite & addr_ok;
	assign rd_en   = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	assign alert_set = uv_event | ot_event | (any_en & pg_fail);
	always_ff @(posedge clk_sys or negedge rst_all_n) begin
		if (!rst_all_n) begin
			ctrl_r    <= 32'h0000_0000;
			vchoice_r <= 8'h00;
			alert_r   <= 1'b0;
		end else begin
			if (wr_en && paddr == `PMSC_REG_CTRL)
				ctrl_r <= pwdata;
			if (wr_en && paddr == `PMSC_REG_VCHOICE)
				vchoice_r <= pwdata[7:0];
			// a new event in the clearing cycle keeps the alert asserted
			if (alert_set)
				alert_r <= 1'b1;
			else if (wr_en && paddr == `PMSC_REG_ALERT_CLR)
				alert_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_all_n) begin
		if (!rst_all_n)
			prdata <= 32'h0000_0000;
		else if (rd_en) begin
			case (paddr)
				`PMSC_REG_CTRL:    prdata <= ctrl_r;
				`PMSC_REG_VCHOICE: prdata <= {24'h00_0000, vchoice_r};
				`PMSC_REG_STATUS:  prdata <= {13'h0000, state_r, rail_good, en_dly_r,
					key_state_r, rails_ok_out};
				`PMSC_REG_ALERT:   prdata <= {31'h0000_0000, alert_r};
				default:           prdata <= 32'h0000_0000;
			endcase
		end
	end

	// open-drain pins: enable high while pulling low
	assign system_up_out = (state_r == PMSC_WAKING) || (state_r == PMSC_ON);
	assign system_up_oe  = ~system_up_out;
	assign key_state_out = key_state_r;
	assign key_state_oe  = ~key_state_r;
	assign reset_out_n   = always_alive_ok & (state_r != PMSC_HARDRST);
	assign reset_out_oe  = ~reset_out_n;
	assign alert_out_n   = ~alert_r;
	assign alert_out_oe  = alert_r;
	assign rails_ok_oe   = ~rails_ok_out;
endmodule

// [verification/pmsc_host_model.sv]
// host processor and pushbutton on the far side of the block
// assumes the bench holds press for as long as the button is down
module pmsc_host_model #(
	parameter int ACK_DLY = 20
) (
	input  wire logic clk_sys,
	input  wire logic system_up_out,
	input  wire logic press,
	input  wire logic ack_en,
	output logic      push_key_n,
	output logic      host_power_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	int up_cyc = 0;
	initial host_power_ack = 1'h0;
	// a released button floats to the pull-up level
	assign push_key_n = ~press;
	// acks only after wake has stood a while; drops it as soon as wake goes
	always @(posedge clk_sys) begin
		up_cyc <= system_up_out ? up_cyc + 1 : 0;
		host_power_ack <= ack_en && up_cyc >= ACK_DLY;
	end
endmodule

// [verification/pmsc_power_sequence_control_test.sv]
// self-checking bench for the power sequence control block
// assumes the host model drives the button and acknowledge pins
module pmsc_power_sequence_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'h0;
	logic        reset_n, logic_supply_ok, psel, penable, pwrite, press, ack_en, er;
	logic        ldo_b_enable, buck_a_enable, buck_b_enable, buck_c_enable, bb_enable;
	logic        ldo_cd_enable, standby_volt_sel, always_alive_ok, uv_event, ot_event;
	logic        push_key_n, host_power_ack, pready, pslverr, system_up_out, key_state_out;
	logic        reset_out_n, alert_out_n, rails_ok_out, system_up_oe, key_state_oe;
	logic        reset_out_oe, alert_out_oe, rails_ok_oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0]  rail_good, rail_slewing, rail_enable;
	logic [3:0]  dac_use_alt;
	logic [1:0]  ldo_d_level;
	int          error_cnt = 0, samples_checked = 0, e, x, c, k;

	always #4 clk_sys = ~clk_sys;

	// short millisecond so that the long presses fit the run
	pmsc_power_sequence_control #(.MS_CYC(10), .EN_DLY(4), .DEB_MS(2), .WAKE_MS(4),
		.HARD_MS(8), .HRST_MS(3), .ACK_MS(6)) u_dut (.*);
	pmsc_host_model u_host (.*);

	task automatic tally_and_finish();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] s, logic [31:0] w);
		samples_checked++;
		if (s !== w) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, w, s);
		end
	endtask

	task automatic wt(int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge clk_sys);
		penable <= 1'h1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_sys);
			if (pready === 1'h1) break;
		end
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
		if (k == 20) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask

	// rail order: buck a, b, c, buck-boost, ldo b, ldo c, ldo d
	function automatic logic [6:0] exp_en(int en, int veto);
		return {en[5] & ~veto[0], en[5], en[4:0]};
	endfunction

	task automatic setl(int en);
		{ldo_cd_enable, ldo_b_enable, bb_enable, buck_c_enable, buck_b_enable, buck_a_enable}
			<= en[5:0];
	endtask

	initial begin
		wt(20000);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		{reset_n, logic_supply_ok, always_alive_ok, psel, penable, pwrite, press, ack_en} = 8'h60;
		{standby_volt_sel, uv_event, ot_event, paddr, pwdata} = '0;
		{rail_good, rail_slewing} = {7'h7F, 7'h00};
		setl(0);
		x = $urandom(32'h14E90328);
		wt(10);
		reset_n <= 1'h1;
		wt(2);
		chk("wake", system_up_out, 1'h0);
		chk("key", key_state_out, 1'h1);
		chk("alert", alert_out_n, 1'h1);
		chk("rails_ok", rails_ok_out, 1'h0);
		chk("pin_oe", {system_up_oe, key_state_oe, reset_out_oe, alert_out_oe, rails_ok_oe}, 5'h11);
		apb(1'h0, 12'h0FC, 32'h0);
		chk("slverr", er, 1'h1);
		chk("unmapped", rd, 32'h0);
		repeat (8) begin
			e = $urandom % 64;
			c = $urandom & 32'h131;
			rail_good <= 7'($urandom | $urandom);
			always_alive_ok <= 1'($urandom);
			apb(1'h1, 12'h000, c);
			setl(e);
			x = exp_en(e, c >> 8);
			rail_slewing <= 7'($urandom & x);
			wt(15);
			chk("rail_en", rail_enable, x);
			chk("level", ldo_d_level, c[5:4]);
			chk("rst_out", reset_out_n, always_alive_ok);
			chk("rails_ok", rails_ok_out,
				x != 0 && (x & ~rail_good) == 0 && (c[0] || rail_slewing == 0));
		end
		always_alive_ok <= 1'h1;
		repeat (4) begin
			c = $urandom % 16;
			e = $urandom % 2;
			apb(1'h1, 12'h008, c);
			apb(1'h0, 12'h008, 32'h0);
			chk("choice", rd, c);
			standby_volt_sel <= e[0];
			ack_en <= 1'($urandom);
			wt(4);
			chk("dac", dac_use_alt, e ? 4'hF : c);
		end
		{rail_good, rail_slewing} <= {7'h7F, 7'h00};
		for (e = 1; e < 4; e++) begin
			wt(6);
			apb(1'h1, 12'h004, 32'h0);
			wt(2);
			chk("alert_idle", alert_out_n, 1'h1);
			{ot_event, uv_event} <= e[1:0];
			wt(5);
			{ot_event, uv_event} <= 2'h0;
			wt(5);
			chk("alert_set", alert_out_n, 1'h0);
		end
		setl(0);
		ack_en <= 1'h1;
		press <= 1'h1;
		wt(40);
		chk("key_down", key_state_out, 1'h0);
		wt(20);
		chk("wake_on", system_up_out, 1'h1);
		press <= 1'h0;
		wt(80);
		chk("key_up", key_state_out, 1'h1);
		chk("wake_kept", system_up_out, 1'h1);
		ack_en <= 1'h0;
		wt(5);
		chk("wake_drop", system_up_out, 1'h0);
		press <= 1'h1;
		wt(60);
		press <= 1'h0;
		wt(80);
		chk("no_ack", system_up_out, 1'h0);
		ack_en <= 1'h1;
		apb(1'h1, 12'h000, 32'h0);
		setl(63);
		wt(15);
		press <= 1'h1;
		wt(80);
		for (e = 0; e < 50 && reset_out_n !== 1'h0; e++) wt(1);
		wt(2);
		chk("hard_rst", reset_out_n, 1'h0);
		chk("hard_off", {system_up_out, rail_enable}, 8'h00);
		press <= 1'h0;
		wt(40);
		chk("inhibit", rail_enable, 7'h00);
		wt(60);
		chk("reenable", rail_enable, 7'h7F);
		apb(1'h1, 12'h000, 32'h30);
		logic_supply_ok <= 1'h0;
		wt(3);
		logic_supply_ok <= 1'h1;
		wt(2);
		chk("supply_loss", ldo_d_level, 2'h0);
		always_alive_ok <= 1'h0;
		wt(5);
		chk("aa_reset", reset_out_n, 1'h0);
		tally_and_finish();
	end
endmodule

// [verification/pmsc_properties.sv]
// port checks for the power sequence control block
// assumes one clock domain; bound to the top module by name
module pmsc_checker (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        host_power_ack,
	input wire logic        standby_volt_sel,
	input wire logic        always_alive_ok,
	input wire logic [6:0]  rail_good,
	input wire logic        uv_event,
	input wire logic        ot_event,
	input wire logic        system_up_out,
	input wire logic        reset_out_n,
	input wire logic        alert_out_n,
	input wire logic        rails_ok_out,
	input wire logic [6:0]  rail_enable,
	input wire logic [3:0]  dac_use_alt
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// five quiet cycles first: a pending event must win over the clear
	property clr_p;
		(!uv_event && !ot_event && (rail_enable & ~rail_good) == 7'h00) [*5] ##0
			(psel && penable && pwrite && paddr == 12'h004) |-> ##[1:2] alert_out_n;
	endproperty
	ack_drop_a: assert property ($fell(host_power_ack) |-> ##[1:4] !system_up_out)
		else $error("wake stays up after ack drop");
	ack_raise_a: assert property ($rose(host_power_ack) && reset_out_n |-> ##[0:3] system_up_out)
		else $error("wake not up after ack");
	alert_set_a: assert property (uv_event || ot_event |-> ##[1:4] !alert_out_n)
		else $error("alert missing");
	alert_clr_a: assert property (clr_p)
		else $error("alert not released");
	rst_low_a: assert property (!always_alive_ok [*3] |-> !reset_out_n)
		else $error("reset not low");
	stby_alt_a: assert property (standby_volt_sel [*3] |-> dac_use_alt == 4'hF)
		else $error("standby targets not forced");
	rails_low_a: assert property ((|(rail_enable & ~rail_good)) [*4] |-> !rails_ok_out)
		else $error("rails ok with a rail down");
	hard_rst_a: assert property ($fell(reset_out_n) && always_alive_ok |->
		##[0:2] (rail_enable == 7'h00 && !system_up_out))
		else $error("rails left on in hard reset");
	cover property ($rose(system_up_out));
	cover property ($fell(alert_out_n));
	cover property ($fell(reset_out_n) && always_alive_ok);
endmodule

bind pmsc_power_sequence_control pmsc_checker u_chk (.*);
